//--- core/ctc_timer.sv
// Capture/compare timer: register slave, event edge logic, counter and output
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none

module ctc_timer
    import ctc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [7:0] avs_writedata_in,
    output logic [7:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic event_in,
    input wire logic companion_timer_clock_in,
    input wire logic companion_restart_in,
    input wire logic standby_in,
    input wire logic debug_halt_in,
    output logic compare_out,
    output logic capture_interrupt_out,
    output logic capture_event_out
);

    // ------------------------------------------------------------
    // Registers and internal signals
    // ------------------------------------------------------------
    logic [7:0] control_a_q, mode_out_q, event_ctrl_q, high_buf_q, rdata_q;
    logic [15:0] count_q, cmp_q;
    logic [1:0] ev_sync_q, comp_clk_sync_q, comp_rst_sync_q;
    logic [CTC_FILTER_SAMPLES-1:0] filt_hist_q;
    // Single-bit state: flags, run state, bus answer, edge history
    logic int_enable_q, capture_int_q, keep_running_in_debug_q, running_q, fp_phase_q;
    logic ack_q, wait_q, out_q, comp_clk_prev_q, comp_rst_prev_q, filt_level_q, ev_prev_q, half_q;
    // Combinational decode of edges, ticks and bus strobes
    logic tick, active, ev_level, pos_edge, neg_edge, sel_edge, opp_edge;
    logic wr_acc, rd_acc, flag_set, at_top, cap_read;
    ctc_mode_t mode;
    ctc_clksrc_t clksrc;

    assign mode = ctc_mode_t'(mode_out_q[2:0]);
    assign clksrc = ctc_clksrc_t'(control_a_q[CTC_BIT_CLKSRC_LO+1:CTC_BIT_CLKSRC_LO]);

    // Bus request accepted only in the cycle the answer is given
    assign wr_acc = avs_write_in && ack_q;
    assign rd_acc = avs_read_in && ack_q;

    // True for the modes where the compare register holds a capture
    function automatic logic is_capture_mode(input ctc_mode_t m);
        is_capture_mode = (m == CTC_MODE_CAPTURE) || (m == CTC_MODE_FREQ) ||
                          (m == CTC_MODE_PULSE) || (m == CTC_MODE_FREQ_PULSE);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pins come from outside the clock domain; two stages each
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ev_sync_q <= 2'h0;
            comp_clk_sync_q <= 2'h0;
            comp_rst_sync_q <= 2'h0;
            comp_clk_prev_q <= 1'b0;
            comp_rst_prev_q <= 1'b0;
        end else begin
            ev_sync_q <= {ev_sync_q[0], event_in};
            comp_clk_sync_q <= {comp_clk_sync_q[0], companion_timer_clock_in};
            comp_rst_sync_q <= {comp_rst_sync_q[0], companion_restart_in};
            comp_clk_prev_q <= comp_clk_sync_q[1];
            comp_rst_prev_q <= comp_rst_sync_q[1];
        end
    end

    // ------------------------------------------------------------
    // Noise canceller and edge detection
    // ------------------------------------------------------------
    // Four equal samples make the level stable; costs five cycles of delay
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            filt_hist_q <= '0;
            filt_level_q <= 1'b0;
        end else begin
            filt_hist_q <= {filt_hist_q[CTC_FILTER_SAMPLES-2:0], ev_sync_q[1]};
            if (&filt_hist_q) begin
                filt_level_q <= 1'b1;
            end else if (~|filt_hist_q) begin
                filt_level_q <= 1'b0;
            end
        end
    end

    assign ev_level = event_ctrl_q[CTC_BIT_FILTER] ? filt_level_q : ev_sync_q[1];

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ev_prev_q <= 1'b0;
        end else begin
            ev_prev_q <= ev_level;
        end
    end

    // Edges count only while enabled and the input is accepted
    assign pos_edge = active && event_ctrl_q[CTC_BIT_EVENT_EN] && ev_level && !ev_prev_q;
    assign neg_edge = active && event_ctrl_q[CTC_BIT_EVENT_EN] && !ev_level && ev_prev_q;
    assign sel_edge = event_ctrl_q[CTC_BIT_EDGE] ? neg_edge : pos_edge;
    assign opp_edge = event_ctrl_q[CTC_BIT_EDGE] ? pos_edge : neg_edge;

    // ------------------------------------------------------------
    // Activity and count tick
    // ------------------------------------------------------------
    // Standby halts unless allowed; companion clock ignores the standby bit
    assign active = control_a_q[CTC_BIT_ENABLE] &&
                    !(debug_halt_in && !keep_running_in_debug_q) &&
                    !(standby_in && !control_a_q[CTC_BIT_RUN_STANDBY] &&
                      clksrc != CTC_CLK_COMPANION);

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            half_q <= 1'b0;
        end else begin
            half_q <= ~half_q;
        end
    end

    // Reserved source never ticks
    always_comb begin
        unique case (clksrc)
            CTC_CLK_PERIPH: tick = active;
            CTC_CLK_HALF: tick = active && half_q;
            CTC_CLK_COMPANION: tick = active && comp_clk_sync_q[1] && !comp_clk_prev_q;
            CTC_CLK_RESERVED: tick = 1'b0;
        endcase
    end

    assign at_top = (mode == CTC_MODE_PWM8) ? (count_q[7:0] == cmp_q[7:0]) : (count_q == cmp_q);
    assign cap_read = rd_acc && avs_address_in == CTC_OFF_CMP_LO && is_capture_mode(mode);

    // ------------------------------------------------------------
    // Counter, run state and capture
    // ------------------------------------------------------------
    // Software writes to the counter win over internal updates
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            count_q <= 16'h0000;
            running_q <= 1'b0;
            fp_phase_q <= 1'b0;
            cmp_q <= 16'h0000;
        end else begin
            if (active && control_a_q[CTC_BIT_RESTART_COMP] && comp_rst_sync_q[1] && !comp_rst_prev_q) begin
                count_q <= 16'h0000;
            end else if (tick && running_q) begin
                if (at_top && mode != CTC_MODE_TIMEOUT && !is_capture_mode(mode)) begin
                    count_q <= 16'h0000;
                end else begin
                    count_q <= count_q + 16'h0001;
                end
            end
            unique case (mode)
                CTC_MODE_PERIODIC, CTC_MODE_PWM8: begin
                    running_q <= active;
                end
                CTC_MODE_TIMEOUT: begin
                    if (sel_edge) begin
                        running_q <= 1'b1;
                    end else if (opp_edge) begin
                        running_q <= 1'b0;
                    end
                end
                CTC_MODE_CAPTURE: begin
                    running_q <= active;
                    if (sel_edge) begin
                        cmp_q <= count_q;
                    end
                end
                CTC_MODE_FREQ: begin
                    running_q <= active;
                    if (sel_edge) begin
                        cmp_q <= count_q;
                        count_q <= 16'h0000;
                    end
                end
                CTC_MODE_PULSE: begin
                    running_q <= active;
                    if (sel_edge) begin
                        count_q <= 16'h0000;
                    end else if (opp_edge) begin
                        cmp_q <= count_q;
                    end
                end
                CTC_MODE_FREQ_PULSE: begin
                    if (sel_edge && !running_q && !capture_int_q) begin
                        count_q <= 16'h0000;
                        running_q <= 1'b1;
                        fp_phase_q <= 1'b0;
                    end else if (opp_edge && running_q && !fp_phase_q) begin
                        cmp_q <= count_q;
                        fp_phase_q <= 1'b1;
                    end else if (sel_edge && running_q && fp_phase_q) begin
                        running_q <= 1'b0;
                    end
                end
                CTC_MODE_SINGLE: begin
                    if (!running_q && (pos_edge || (event_ctrl_q[CTC_BIT_EDGE] && neg_edge))) begin
                        running_q <= 1'b1;
                        count_q <= 16'h0000;
                    end else if (tick && running_q && at_top) begin
                        running_q <= 1'b0;
                    end
                end
            endcase
            if (!control_a_q[CTC_BIT_ENABLE]) begin
                running_q <= 1'b0;
            end
            if (wr_acc && avs_address_in == CTC_OFF_COUNT_LO) begin
                count_q <= {high_buf_q, avs_writedata_in};
            end
            if (wr_acc && avs_address_in == CTC_OFF_CMP_LO) begin
                cmp_q <= {high_buf_q, avs_writedata_in};
            end
        end
    end

    // ------------------------------------------------------------
    // Capture flag, event strobe and interrupt
    // ------------------------------------------------------------
    always_comb begin
        unique case (mode)
            CTC_MODE_CAPTURE, CTC_MODE_FREQ: flag_set = sel_edge;
            CTC_MODE_PULSE: flag_set = opp_edge;
            CTC_MODE_FREQ_PULSE: flag_set = sel_edge && running_q && fp_phase_q;
            default: flag_set = tick && running_q && at_top;
        endcase
    end

    // New event beats a clear in the same cycle
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            capture_int_q <= 1'b0;
            capture_event_out <= 1'b0;
            capture_interrupt_out <= 1'b0;
        end else begin
            if (flag_set) begin
                capture_int_q <= 1'b1;
            end else if ((wr_acc && avs_address_in == CTC_OFF_INT_FLAG &&
                          avs_writedata_in[CTC_BIT_CAPTURE_INT]) || cap_read) begin
                capture_int_q <= 1'b0;
            end
            capture_event_out <= flag_set;
            capture_interrupt_out <= (capture_int_q || flag_set) && int_enable_q;
        end
    end

    // ------------------------------------------------------------
    // Compare output
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            out_q <= 1'b0;
            compare_out <= 1'b0;
        end else begin
            if (!control_a_q[CTC_BIT_ENABLE]) begin
                out_q <= mode_out_q[CTC_BIT_INIT_LEVEL];
            end else if (mode == CTC_MODE_SINGLE) begin
                if (mode_out_q[CTC_BIT_IMMEDIATE] && !running_q &&
                    (pos_edge || (event_ctrl_q[CTC_BIT_EDGE] && neg_edge))) begin
                    out_q <= 1'b1;
                end else begin
                    out_q <= running_q;
                end
            end else if (mode == CTC_MODE_PWM8) begin
                out_q <= (count_q[7:0] < cmp_q[15:8]);
            end else begin
                out_q <= mode_out_q[CTC_BIT_INIT_LEVEL];
            end
            compare_out <= mode_out_q[CTC_BIT_OUT_ENABLE] && out_q;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            control_a_q <= CTC_RESET_BYTE;
            mode_out_q <= CTC_RESET_BYTE;
            event_ctrl_q <= CTC_RESET_BYTE;
            int_enable_q <= 1'b0;
            keep_running_in_debug_q <= 1'b0;
            high_buf_q <= CTC_RESET_BYTE;
        end else if (wr_acc) begin
            unique case (avs_address_in)
                CTC_OFF_CONTROL_A: control_a_q <= avs_writedata_in & CTC_MASK_CONTROL_A;
                CTC_OFF_MODE_OUT: mode_out_q <= avs_writedata_in & CTC_MASK_MODE_OUT;
                CTC_OFF_EVENT_CTRL: event_ctrl_q <= avs_writedata_in & CTC_MASK_EVENT_CTRL;
                CTC_OFF_INT_ENABLE: int_enable_q <= avs_writedata_in[0];
                CTC_OFF_DEBUG_HALT: keep_running_in_debug_q <= avs_writedata_in[0];
                CTC_OFF_HIGH_BUF, CTC_OFF_COUNT_HI, CTC_OFF_CMP_HI: high_buf_q <= avs_writedata_in;
                default: ;
            endcase
        end else if (rd_acc && avs_address_in == CTC_OFF_COUNT_LO) begin
            high_buf_q <= count_q[15:8];
        end else if (rd_acc && avs_address_in == CTC_OFF_CMP_LO) begin
            high_buf_q <= cmp_q[15:8];
        end
    end

    // ------------------------------------------------------------
    // Bus answer: one wait cycle, then data with waitrequest low
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ack_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= 8'h00;
        end else begin
            ack_q <= (avs_read_in || avs_write_in) && !ack_q;
            // Own flop for the pin, so no gate sits behind it
            wait_q <= !((avs_read_in || avs_write_in) && wait_q);
            unique case (avs_address_in)
                CTC_OFF_CONTROL_A: rdata_q <= control_a_q;
                CTC_OFF_MODE_OUT: rdata_q <= mode_out_q;
                CTC_OFF_EVENT_CTRL: rdata_q <= event_ctrl_q;
                CTC_OFF_INT_ENABLE: rdata_q <= {7'h00, int_enable_q};
                CTC_OFF_INT_FLAG: rdata_q <= {7'h00, capture_int_q};
                CTC_OFF_RUN_STATE: rdata_q <= {7'h00, running_q};
                CTC_OFF_DEBUG_HALT: rdata_q <= {7'h00, keep_running_in_debug_q};
                CTC_OFF_HIGH_BUF, CTC_OFF_COUNT_HI, CTC_OFF_CMP_HI: rdata_q <= high_buf_q;
                CTC_OFF_COUNT_LO: rdata_q <= count_q[7:0];
                CTC_OFF_CMP_LO: rdata_q <= cmp_q[7:0];
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence out_off_s;
        !mode_out_q[CTC_BIT_OUT_ENABLE];
    endsequence

    output_gate_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        out_off_s ##1 out_off_s |-> !compare_out) else $error("output not forced low");
    disabled_idle_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        !control_a_q[CTC_BIT_ENABLE] |=> !running_q) else $error("runs while disabled");
    flag_set_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        flag_set |=> capture_int_q) else $error("flag lost on set");
    flag_clear_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        cap_read && !flag_set |=> !capture_int_q) else $error("capture read kept flag");
    capture_load_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        mode == CTC_MODE_CAPTURE && sel_edge && !wr_acc |=> cmp_q == $past(count_q))
        else $error("capture missed");
    freq_clear_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        mode == CTC_MODE_FREQ && sel_edge && !wr_acc |=> count_q == 16'h0000)
        else $error("frequency restart missed");
    timeout_start_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        mode == CTC_MODE_TIMEOUT && sel_edge && control_a_q[CTC_BIT_ENABLE] |=> running_q)
        else $error("timeout start missed");
    periodic_ignore_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        mode == CTC_MODE_PERIODIC && !flag_set |=> $stable(cmp_q) || $past(wr_acc))
        else $error("periodic mode reacted");
    reserved_read_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        avs_address_in == 4'h2 |=> rdata_q == 8'h00) else $error("reserved read nonzero");
    reserved_clk_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        clksrc == CTC_CLK_RESERVED |-> !tick) else $error("reserved clock ticks");

endmodule

`default_nettype wire

//--- shared/ctc_pkg.sv
// Package with register map, field positions and mode codes of the capture timer
package ctc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] CTC_OFF_CONTROL_A = 4'h0;
    localparam logic [3:0] CTC_OFF_MODE_OUT = 4'h1;
    localparam logic [3:0] CTC_OFF_EVENT_CTRL = 4'h4;
    localparam logic [3:0] CTC_OFF_INT_ENABLE = 4'h5;
    localparam logic [3:0] CTC_OFF_INT_FLAG = 4'h6;
    localparam logic [3:0] CTC_OFF_RUN_STATE = 4'h7;
    localparam logic [3:0] CTC_OFF_DEBUG_HALT = 4'h8;
    localparam logic [3:0] CTC_OFF_HIGH_BUF = 4'h9;
    localparam logic [3:0] CTC_OFF_COUNT_LO = 4'ha;
    localparam logic [3:0] CTC_OFF_COUNT_HI = 4'hb;
    localparam logic [3:0] CTC_OFF_CMP_LO = 4'hc;
    localparam logic [3:0] CTC_OFF_CMP_HI = 4'hd;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTC_BIT_ENABLE = 0;
    localparam int CTC_BIT_CLKSRC_LO = 1;
    localparam int CTC_BIT_RESTART_COMP = 4;
    localparam int CTC_BIT_RUN_STANDBY = 6;
    localparam int CTC_BIT_IMMEDIATE = 6;
    localparam int CTC_BIT_INIT_LEVEL = 5;
    localparam int CTC_BIT_OUT_ENABLE = 4;
    localparam int CTC_BIT_FILTER = 6;
    localparam int CTC_BIT_EDGE = 4;
    localparam int CTC_BIT_EVENT_EN = 0;
    localparam int CTC_BIT_CAPTURE_INT = 0;

    // Writable bit masks; other bits read zero
    localparam logic [7:0] CTC_MASK_CONTROL_A = 8'h57;
    localparam logic [7:0] CTC_MASK_MODE_OUT = 8'h77;
    localparam logic [7:0] CTC_MASK_EVENT_CTRL = 8'h51;
    localparam logic [7:0] CTC_MASK_BIT0 = 8'h01;
    localparam logic [7:0] CTC_RESET_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Clock sources and modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CTC_CLK_PERIPH = 2'b00,
        CTC_CLK_HALF = 2'b01,
        CTC_CLK_COMPANION = 2'b10,
        CTC_CLK_RESERVED = 2'b11
    } ctc_clksrc_t;

    typedef enum logic [2:0] {
        CTC_MODE_PERIODIC = 3'b000,
        CTC_MODE_TIMEOUT = 3'b001,
        CTC_MODE_CAPTURE = 3'b010,
        CTC_MODE_FREQ = 3'b011,
        CTC_MODE_PULSE = 3'b100,
        CTC_MODE_FREQ_PULSE = 3'b101,
        CTC_MODE_SINGLE = 3'b110,
        CTC_MODE_PWM8 = 3'b111
    } ctc_mode_t;

    // Noise filter needs this many equal samples
    localparam int CTC_FILTER_SAMPLES = 4;

endpackage

//--- verif/ctc_partner.sv
// Far-side model: event channel and companion timer
`timescale 1ns/10ps
`default_nettype none
module ctc_partner (
    input wire logic mclk_in,
    output logic event_out,
    output logic comp_clk_out,
    output logic comp_rst_out
);
    // Companion clock stands still: it never ticks in this model
    initial begin
        event_out = 1'b0;
        comp_clk_out = 1'b0;
        comp_rst_out = 1'b0;
    end
    // Each level is held whole cycles, never under one
    task automatic drive(input logic lvl, input int n);
        event_out <= lvl;
        repeat (n) @(posedge mclk_in);
    endtask
    // Long pulse so the two-stage sampler cannot miss it
    task automatic restart();
        comp_rst_out <= 1'b1;
        repeat (4) @(posedge mclk_in);
        comp_rst_out <= 1'b0;
        repeat (4) @(posedge mclk_in);
    endtask
endmodule
`default_nettype wire

//--- verif/test_capture_timer_control_and_edges.sv
// Self-checking bench for the capture timer control and event edges
`timescale 1ns/10ps
`default_nettype none
module test_capture_timer_control_and_edges
    import ctc_pkg::*;
;
    logic mclk_in, srst_in, rd_en, wr_en, waitreq, ev, cclk, crst, cmp_o, irq, cev, pe, sb;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, q;
    logic [2:0] m;
    logic [2:0] modes [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
    int n_fail = 0;
    int cmp_count = 0;
    int i, ev0;
    int n_ev = 0;

    ctc_timer uut (.mclk_in(mclk_in), .srst_in(srst_in), .avs_address_in(addr), .avs_read_in(rd_en),
        .avs_write_in(wr_en), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .event_in(ev), .companion_timer_clock_in(cclk),
        .companion_restart_in(crst), .standby_in(sb), .debug_halt_in(1'b0),
        .compare_out(cmp_o), .capture_interrupt_out(irq), .capture_event_out(cev));
    ctc_partner p (.mclk_in(mclk_in), .event_out(ev), .comp_clk_out(cclk), .comp_rst_out(crst));

    // Free-running 100 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    // Verdict and end of run, also reached when a wait runs out
    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Counts one-cycle strobes on the event output
    always @(posedge mclk_in) begin
        if (cev === 1'b1) begin
            n_ev++;
        end
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One bus cycle; held until waitrequest is sampled low, bounded
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int k;
        addr <= a;
        wr_en <= w;
        rd_en <= !w;
        wdata <= d;
        k = 0;
        do begin
            @(posedge mclk_in);
            k++;
        end while (waitreq !== 1'b0 && k < 40);
        q = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        if (waitreq !== 1'b0) begin
            n_fail++;
            wrap_up();
        end else begin
            @(posedge mclk_in);
        end
    endtask

    initial begin
        srst_in = 1'b1;
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        sb = 1'b0;
        repeat (12) @(posedge mclk_in);
        srst_in <= 1'b0;
        // --------------------------------
        // Reset values, masks, unmapped
        // --------------------------------
        bus(1'b0, CTC_OFF_EVENT_CTRL, 8'h00);
        chk("event_input_control reset", 8'h00, q);
        bus(1'b1, 4'h2, 8'hff);
        bus(1'b0, 4'h2, 8'h00);
        chk("unmapped", 8'h00, q);
        bus(1'b1, CTC_OFF_CONTROL_A, 8'hff);
        bus(1'b0, CTC_OFF_CONTROL_A, 8'h00);
        chk("ctrl a mask", 8'h57, q);
        bus(1'b1, CTC_OFF_CONTROL_A, 8'h00);
        // Output pin level, timer still disabled
        bus(1'b1, CTC_OFF_MODE_OUT, 8'h20);
        chk("out gated", 8'h00, {7'h00, cmp_o});
        bus(1'b1, CTC_OFF_MODE_OUT, 8'h30);
        // Pin flop updates on the bus task's last edge; look one edge later
        @(posedge mclk_in);
        chk("out init", 8'h01, {7'h00, cmp_o});
        $display("Test registers done");
        // Top at its maximum so periodic mode never flags here
        bus(1'b1, CTC_OFF_CMP_HI, 8'hff);
        bus(1'b1, CTC_OFF_CMP_LO, 8'hff);
        bus(1'b1, CTC_OFF_INT_ENABLE, 8'h01);
        bus(1'b1, CTC_OFF_CONTROL_A, 8'h01);
        // Edge table per mode and edge bit; fall flag is the inverse in capture modes
        for (i = 0; i < 8; i++) begin
            m = modes[i / 2];
            pe = (m == 3'h0) ? 1'b0 : ((m == 3'h4) ? i[0] : !i[0]);
            bus(1'b1, CTC_OFF_EVENT_CTRL, {3'b000, i[0], 4'h1});
            bus(1'b1, CTC_OFF_MODE_OUT, {5'h00, m});
            bus(1'b1, CTC_OFF_INT_FLAG, 8'h01);
            p.drive(1'b1, 8);
            bus(1'b0, CTC_OFF_INT_FLAG, 8'h00);
            chk("flag on rise", {7'h00, pe}, q);
            chk("irq on rise", {7'h00, pe}, {7'h00, irq});
            bus(1'b0, CTC_OFF_CMP_LO, 8'h00);
            p.drive(1'b0, 8);
            bus(1'b0, CTC_OFF_INT_FLAG, 8'h00);
            chk("flag on fall", {7'h00, pe ^ (m != 3'h0)}, q);
        end
        $display("Test edge table done");
        // Events refused, then glitch filtered, then a steady level passes
        bus(1'b1, CTC_OFF_MODE_OUT, 8'h02);
        bus(1'b1, CTC_OFF_EVENT_CTRL, 8'h00);
        bus(1'b1, CTC_OFF_INT_FLAG, 8'h01);
        p.drive(1'b1, 8);
        p.drive(1'b0, 8);
        bus(1'b0, CTC_OFF_INT_FLAG, 8'h00);
        chk("input off", 8'h00, q);
        bus(1'b1, CTC_OFF_EVENT_CTRL, 8'h41);
        p.drive(1'b1, 2);
        p.drive(1'b0, 8);
        bus(1'b0, CTC_OFF_INT_FLAG, 8'h00);
        chk("glitch", 8'h00, q);
        p.drive(1'b1, 10);
        bus(1'b0, CTC_OFF_INT_FLAG, 8'h00);
        chk("filtered", 8'h01, q);
        p.drive(1'b0, 8);
        $display("Test filter done");
        // Companion clock idle, then companion restart clears the count
        bus(1'b1, CTC_OFF_MODE_OUT, 8'h00);
        bus(1'b1, CTC_OFF_CONTROL_A, 8'h15);
        bus(1'b1, CTC_OFF_COUNT_HI, 8'h12);
        bus(1'b1, CTC_OFF_COUNT_LO, 8'h34);
        bus(1'b0, CTC_OFF_COUNT_LO, 8'h00);
        chk("count held", 8'h34, q);
        p.restart();
        bus(1'b0, CTC_OFF_COUNT_LO, 8'h00);
        chk("restarted", 8'h00, q);
        bus(1'b1, CTC_OFF_CONTROL_A, 8'h07);
        bus(1'b1, CTC_OFF_COUNT_LO, 8'h56);
        bus(1'b0, CTC_OFF_COUNT_LO, 8'h00);
        chk("reserved src", 8'h56, q);
        bus(1'b1, CTC_OFF_CONTROL_A, 8'h00);
        bus(1'b1, CTC_OFF_COUNT_LO, 8'h78);
        bus(1'b0, CTC_OFF_COUNT_LO, 8'h00);
        chk("disabled", 8'h78, q);
        sb <= 1'b1;
        bus(1'b1, CTC_OFF_CONTROL_A, 8'h01);
        bus(1'b1, CTC_OFF_COUNT_LO, 8'h9a);
        bus(1'b0, CTC_OFF_COUNT_LO, 8'h00);
        chk("standby halt", 8'h9a, q);
        bus(1'b1, CTC_OFF_CONTROL_A, 8'h00);
        sb <= 1'b0;
        $display("Test clock source done");
        // Single-shot pulse from one rising edge, then time-out start and stop
        bus(1'b1, CTC_OFF_CMP_HI, 8'h00);
        bus(1'b1, CTC_OFF_CMP_LO, 8'h20);
        bus(1'b1, CTC_OFF_MODE_OUT, 8'h16);
        bus(1'b1, CTC_OFF_EVENT_CTRL, 8'h01);
        bus(1'b1, CTC_OFF_INT_FLAG, 8'h01);
        bus(1'b1, CTC_OFF_CONTROL_A, 8'h01);
        ev0 = n_ev;
        p.drive(1'b1, 8);
        bus(1'b0, CTC_OFF_RUN_STATE, 8'h00);
        chk("shot running", 8'h01, q);
        chk("shot output", 8'h01, {7'h00, cmp_o});
        p.drive(1'b0, 40);
        bus(1'b0, CTC_OFF_RUN_STATE, 8'h00);
        chk("shot stopped", 8'h00, q);
        chk("shot low", 8'h00, {7'h00, cmp_o});
        bus(1'b0, CTC_OFF_INT_FLAG, 8'h00);
        chk("shot top flag", 8'h01, q);
        chk("shot strobe", 8'h01, 8'(n_ev - ev0));
        bus(1'b1, CTC_OFF_MODE_OUT, 8'h01);
        p.drive(1'b1, 8);
        bus(1'b0, CTC_OFF_RUN_STATE, 8'h00);
        chk("timeout start", 8'h01, q);
        p.drive(1'b0, 8);
        bus(1'b0, CTC_OFF_RUN_STATE, 8'h00);
        chk("timeout stop", 8'h00, q);
        $display("Test single shot and timeout done");
        wrap_up();
    end
endmodule
`default_nettype wire
